// [common/acs_defs.vh]
// constants for the serial status, mode and command block
// Function
// - status bits 7 and 6 read one
// - status bit 2 always reads zero
// - bit 5 framing error, cleared three ways
// - bit 4 overrun, sticky until disable/reset-error
// - bit 3 parity error only when checking
// - parity flag cleared by disable, reset, next
// - bit 1 set while receive buffer holds data
// - receive-ready clears on reading the last character or disable
// - bit 0 set while holding register empty
// - transmit-ready clears on write or disable
// - mode one bits 7-6 select stop bits
// - bit 5 parity type, bit 4 parity enable
// - mode one bits 1-0 set clock factor
// - mode registers share address, one then two
// - mode two bits 7-4 fixed clock source
// - mode two bits 3-0 pick baud rate
// - command bit 4 clears all error flags
// - command bit 2 enables the receiver
// - command bit 0 enables the transmitter
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH
// register offsets within the port window
`define ACS_OFS_DATA      2'h0
`define ACS_OFS_STATUS    2'h1
`define ACS_OFS_MODE      2'h2
`define ACS_OFS_CMD       2'h3
// status bit positions
`define ACS_ST_DSR        7
`define ACS_ST_DCD        6
`define ACS_ST_FE         5
`define ACS_ST_OE         4
`define ACS_ST_PE         3
`define ACS_ST_DSRCHG     2
`define ACS_ST_RX_CHAR_WAITING      1
`define ACS_ST_TX_HOLDING_EMPTY      0
// command bit positions
`define ACS_CMD_RSTERR    4
`define ACS_CMD_BREAK     3
`define ACS_CMD_RXEN      2
`define ACS_CMD_TXEN      0
// mode one field positions
`define ACS_M1_PEVEN      5
`define ACS_M1_PEN        4
// reset values
`define ACS_M1_RST        8'h00
`define ACS_M2_RST        4'h0
`define ACS_CMD_RST       8'h00
`define ACS_CLKSRC_FIXED  4'h7
// timing: ticks per bit at 16x oversampling
`define ACS_OVERSAMPLE    16
`define ACS_CLK_HZ        100000000
`define ACS_FIFO_DEPTH    4
`endif

// [hdl/acs_fifo.v]
// small receive fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module acs_fifo #(
   parameter W  = 8,
   parameter D  = 4,
   parameter AW = 2
) (
   input  wire         mclk,
   input  wire         rst_n,
   input  wire         flush,
   input  wire         in_valid,
   output wire         in_ready,
   input  wire [W-1:0] in_data,
   output wire         out_valid,
   input  wire         out_ready,
   output wire [W-1:0] out_data
);
   reg [W-1:0] mem [0:D-1];   // storage array
   reg [AW-1:0] wr_ff;        // write pointer
   reg [AW-1:0] rd_ff;        // read pointer
   reg [AW:0]   cnt_ff;       // fill level
   wire         push;
   wire         pop;
   assign in_ready  = (cnt_ff != D[AW:0]);
   assign out_valid = (cnt_ff != {(AW+1){1'b0}});
   assign out_data  = mem[rd_ff];
   assign push = in_valid & in_ready;
   assign pop  = out_valid & out_ready;
   // pointer and level update, flush empties everything
   always @(posedge mclk) begin
      if (!rst_n || flush) begin
         wr_ff  <= {AW{1'b0}};
         rd_ff  <= {AW{1'b0}};
         cnt_ff <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ff <= (wr_ff == D-1) ? {AW{1'b0}} : wr_ff + 1'b1;
         end
         if (pop) begin
            rd_ff <= (rd_ff == D-1) ? {AW{1'b0}} : rd_ff + 1'b1;
         end
         if (push && !pop) begin
            cnt_ff <= cnt_ff + 1'b1;
         end else if (pop && !push) begin
            cnt_ff <= cnt_ff - 1'b1;
         end
      end
   end
   // data write, no reset needed for storage
   always @(posedge mclk) begin
      if (push) begin
         mem[wr_ff] <= in_data;
      end
   end
endmodule
`default_nettype wire

// [hdl/acs_baud.v]
// baud divider producing a one-cycle 16x tick
`timescale 1ns/10ps
`default_nettype none
`include "acs_defs.vh"
module acs_baud #(
   parameter CLK_HZ = `ACS_CLK_HZ
) (
   input  wire       mclk,
   input  wire       rst_n,
   input  wire [3:0] rate_code,
   output reg        tick_ff
);
   reg [20:0] cnt_ff;   // cycles since last tick
   // twice the baud rate, so 134.5 stays whole
   function [15:0] acs_rate2;
      input [3:0] c;
      begin
         case (c)
            4'h0: acs_rate2 = 16'd100;
            4'h1: acs_rate2 = 16'd150;
            4'h2: acs_rate2 = 16'd220;
            4'h3: acs_rate2 = 16'd269;
            4'h4: acs_rate2 = 16'd300;
            4'h5: acs_rate2 = 16'd600;
            4'h6: acs_rate2 = 16'd1200;
            4'h7: acs_rate2 = 16'd2400;
            4'h8: acs_rate2 = 16'd3600;
            4'h9: acs_rate2 = 16'd4000;
            4'ha: acs_rate2 = 16'd4800;
            4'hb: acs_rate2 = 16'd7200;
            4'hc: acs_rate2 = 16'd9600;
            4'hd: acs_rate2 = 16'd14400;
            4'he: acs_rate2 = 16'd19200;
            default: acs_rate2 = 16'd38400;
         endcase
      end
   endfunction
   wire [31:0] div_full = (2 * CLK_HZ) / (acs_rate2(rate_code) * `ACS_OVERSAMPLE);
   wire [20:0] div = (div_full[20:0] < 21'd1) ? 21'd1 : div_full[20:0];
   // free running divider, count to div then pulse
   always @(posedge mclk) begin
      if (!rst_n) begin
         cnt_ff  <= 21'h0;
         tick_ff <= 1'b0;
      end else if (cnt_ff >= div - 21'd1) begin
         cnt_ff  <= 21'h0;
         tick_ff <= 1'b1;
      end else begin
         cnt_ff  <= cnt_ff + 21'd1;
         tick_ff <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// [hdl/acs_top.v]
// serial controller: registers, status flags, receiver and transmitter
`timescale 1ns/10ps
`default_nettype none
`include "acs_defs.vh"
module acs_top #(
   parameter CLK_HZ = `ACS_CLK_HZ
) (
   input  wire       mclk,
   input  wire       rst_n,
   input  wire       io_cs,
   input  wire [1:0] io_addr,
   input  wire       io_rd,
   input  wire       io_wr,
   input  wire [7:0] io_wdata,
   output reg  [7:0] io_rdata_ff,
   input  wire       rxd,
   output reg        txd_ff,
   output reg        rx_int_pend_ff,
   output reg        tx_int_pend_ff
);
   // state codes for receiver and transmitter
   localparam S_IDLE  = 3'd0;
   localparam S_START = 3'd1;
   localparam S_DATA  = 3'd2;
   localparam S_PAR   = 3'd3;
   localparam S_STOP  = 3'd4;

   // programmable state
   reg [7:0] mode1_ff;        // line format
   reg [3:0] mode2_ff;        // baud rate code
   reg       mptr_ff;         // shared address pointer, 0 = mode one
   reg [7:0] cmd_ff;          // command bits, bit 4 never stored
   // error flags
   reg       fe_ff;           // framing error
   reg       oe_ff;           // overrun
   reg       pe_ff;           // parity error
   // transmit holding register
   reg [7:0] thr_ff;
   reg       thr_full_ff;
   // receiver state
   reg [2:0] rx_st_ff;
   reg [3:0] rx_cnt_ff;
   reg [2:0] rx_bit_ff;
   reg [7:0] rx_sh_ff;
   reg       rx_pbit_ff;
   // transmitter state
   reg [2:0] tx_st_ff;
   reg [5:0] tx_cnt_ff;
   reg [2:0] tx_bit_ff;
   reg [7:0] tx_sh_ff;

   wire       tick;           // 16x bit-rate enable
   wire       rx_en   = cmd_ff[`ACS_CMD_RXEN];
   wire       tx_en   = cmd_ff[`ACS_CMD_TXEN];
   wire       par_en  = mode1_ff[`ACS_M1_PEN];
   wire       par_ev  = mode1_ff[`ACS_M1_PEVEN];
   wire [2:0] len_m1  = {1'b0, mode1_ff[3:2]} + 3'd4;  // data bits minus one
   wire [1:0] factor  = mode1_ff[1:0];                 // clock factor

   // bus strobes decoded by port offset
   wire wr_data = io_cs && io_wr && (io_addr == `ACS_OFS_DATA);
   wire wr_mode = io_cs && io_wr && (io_addr == `ACS_OFS_MODE);
   wire wr_cmd  = io_cs && io_wr && (io_addr == `ACS_OFS_CMD);
   wire rd_data = io_cs && io_rd && (io_addr == `ACS_OFS_DATA);
   wire rd_stat = io_cs && io_rd && (io_addr == `ACS_OFS_STATUS);
   wire rd_mode = io_cs && io_rd && (io_addr == `ACS_OFS_MODE);
   wire rst_err = wr_cmd && io_wdata[`ACS_CMD_RSTERR];

   // receive fifo signals
   wire       rx_done;        // stop bit sampled
   wire       fifo_in_ready;
   wire       fifo_valid;
   wire [7:0] fifo_data;
   wire       rx_pop = rd_data && rx_en;
   wire       rx_new = rx_done && rx_en;

   // parity of received data against the parity bit
   wire rx_perr = par_en && ((^rx_sh_ff ^ rx_pbit_ff) ^ ~par_ev);

   // transmit stop length in ticks: 1, 1.5 or 2 bits, invalid acts as one
   wire [5:0] stop_ticks = (mode1_ff[7:6] == 2'b10) ? 6'd24 :
                           (mode1_ff[7:6] == 2'b11) ? 6'd32 : 6'd16;
   // factor codes 00 and 01 sample at bit start, 10 and 11 at mid-bit
   wire [3:0] mid_tick = (factor == 2'b00 || factor == 2'b01) ? 4'd0 : 4'd7;

   acs_baud #(
      .CLK_HZ    (CLK_HZ)
   ) u_baud (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .rate_code (mode2_ff),
      .tick_ff   (tick)
   );

   acs_fifo #(
      .W         (8),
      .D         (`ACS_FIFO_DEPTH),
      .AW        (2)
   ) u_rxfifo (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .flush     (!rx_en),
      .in_valid  (rx_new),
      .in_ready  (fifo_in_ready),
      .in_data   (rx_sh_ff),
      .out_valid (fifo_valid),
      .out_ready (rx_pop),
      .out_data  (fifo_data)
   );

   // mode, command and pointer registers
   always @(posedge mclk) begin
      if (!rst_n) begin
         mode1_ff <= `ACS_M1_RST;
         mode2_ff <= `ACS_M2_RST;
         cmd_ff   <= `ACS_CMD_RST;
         mptr_ff  <= 1'b0;
      end else begin
         if (wr_mode && !mptr_ff) begin
            mode1_ff <= io_wdata;
         end else if (wr_mode && mptr_ff) begin
            mode2_ff <= io_wdata[3:0];                   // clock source bits dropped
         end
         // pointer steps one then two, then back to one
         if (wr_mode || rd_mode) begin
            mptr_ff <= ~mptr_ff;
         end
         // command bits stored except reset-error
         if (wr_cmd) begin
            cmd_ff <= {io_wdata[7:5], 1'b0, io_wdata[3:0]};
         end
      end
   end

   // error flags: setting event wins over any clear in the same cycle
   always @(posedge mclk) begin
      if (!rst_n) begin
         fe_ff <= 1'b0;
         oe_ff <= 1'b0;
         pe_ff <= 1'b0;
      end else begin
         // framing: cleared by disable, reset-error or status read
         if (rx_new && !rxd) begin
            fe_ff <= 1'b1;
         end else if (!rx_en || rst_err || rd_stat) begin
            fe_ff <= 1'b0;
         end
         // overrun: status read leaves it alone
         if (rx_new && !fifo_in_ready) begin
            oe_ff <= 1'b1;
         end else if (!rx_en || rst_err) begin
            oe_ff <= 1'b0;
         end
         // parity: each new character replaces the flag
         if (rx_new) begin
            pe_ff <= rx_perr;
         end else if (!rx_en || rst_err) begin
            pe_ff <= 1'b0;
         end
      end
   end

   // read data mux, registered one cycle after the strobe
   always @(posedge mclk) begin
      if (!rst_n) begin
         io_rdata_ff <= 8'h00;
      end else if (io_cs && io_rd) begin
         if (io_addr == `ACS_OFS_DATA) begin
            io_rdata_ff <= fifo_valid ? fifo_data : 8'h00;
         end else if (io_addr == `ACS_OFS_STATUS) begin
            io_rdata_ff <= {1'b1,
                            1'b1,
                            fe_ff,
                            oe_ff,
                            pe_ff,
                            1'b0,
                            rx_en && fifo_valid,
                            tx_en && !thr_full_ff};
         end else if (io_addr == `ACS_OFS_MODE) begin
            io_rdata_ff <= mptr_ff ? {`ACS_CLKSRC_FIXED, mode2_ff} : mode1_ff;
         end else begin
            io_rdata_ff <= cmd_ff;                       // bit 4 stored as zero
         end
      end
   end

   // pending interrupt levels follow the ready conditions
   always @(posedge mclk) begin
      if (!rst_n) begin
         rx_int_pend_ff <= 1'b0;
         tx_int_pend_ff <= 1'b0;
      end else begin
         rx_int_pend_ff <= rx_en && fifo_valid && !rx_pop;
         tx_int_pend_ff <= tx_en && !thr_full_ff && !wr_data;
      end
   end

   // receiver: start detect, data, optional parity, stop
   assign rx_done = tick && (rx_st_ff == S_STOP) && (rx_cnt_ff == 4'd15);
   always @(posedge mclk) begin
      if (!rst_n || !rx_en) begin
         rx_st_ff   <= S_IDLE;
         rx_cnt_ff  <= 4'h0;
         rx_bit_ff  <= 3'h0;
         rx_sh_ff   <= 8'h00;
         rx_pbit_ff <= 1'b0;
      end else if (tick) begin
         rx_cnt_ff <= rx_cnt_ff + 4'd1;
         case (rx_st_ff)
            S_IDLE: begin
               rx_cnt_ff <= 4'h0;
               if (!rxd) begin
                  rx_st_ff <= S_START;
               end
            end
            S_START: begin
               // confirm start at the sample point, then align to bit ends
               if (rx_cnt_ff == mid_tick) begin
                  if (rxd) begin
                     rx_st_ff <= S_IDLE;
                  end else begin
                     rx_st_ff  <= S_DATA;
                     rx_cnt_ff <= 4'h0;
                     rx_bit_ff <= 3'h0;
                     rx_sh_ff  <= 8'h00;
                  end
               end
            end
            S_DATA: begin
               if (rx_cnt_ff == 4'd15) begin
                  rx_sh_ff[rx_bit_ff] <= rxd;            // lsb first
                  if (rx_bit_ff == len_m1) begin
                     rx_st_ff <= par_en ? S_PAR : S_STOP;
                  end else begin
                     rx_bit_ff <= rx_bit_ff + 3'd1;
                  end
               end
            end
            S_PAR: begin
               if (rx_cnt_ff == 4'd15) begin
                  rx_pbit_ff <= rxd;
                  rx_st_ff   <= S_STOP;
               end
            end
            S_STOP: begin
               if (rx_cnt_ff == 4'd15) begin
                  rx_st_ff <= S_IDLE;
               end
            end
            default: begin
               rx_st_ff <= S_IDLE;
            end
         endcase
      end
   end

   // transmit holding register: load on write, empty on shifter load
   always @(posedge mclk) begin
      if (!rst_n || !tx_en) begin
         thr_ff      <= 8'h00;
         thr_full_ff <= 1'b0;
      end else if (wr_data) begin
         thr_ff      <= io_wdata;
         thr_full_ff <= 1'b1;
      end else if (tick && tx_st_ff == S_IDLE && thr_full_ff) begin
         thr_full_ff <= 1'b0;
      end
   end

   // transmitter: start, data, parity, stop of chosen length
   always @(posedge mclk) begin
      if (!rst_n) begin
         tx_st_ff  <= S_IDLE;
         tx_cnt_ff <= 6'h0;
         tx_bit_ff <= 3'h0;
         tx_sh_ff  <= 8'h00;
         txd_ff    <= 1'b1;
      end else if (tick) begin
         tx_cnt_ff <= tx_cnt_ff + 6'd1;
         case (tx_st_ff)
            S_IDLE: begin
               tx_cnt_ff <= 6'h0;
               txd_ff    <= 1'b1;
               if (thr_full_ff && tx_en) begin
                  tx_sh_ff <= thr_ff;
                  tx_st_ff <= S_START;
                  txd_ff   <= 1'b0;
               end
            end
            S_START: begin
               if (tx_cnt_ff == 6'd15) begin
                  tx_st_ff  <= S_DATA;
                  tx_cnt_ff <= 6'h0;
                  tx_bit_ff <= 3'h0;
                  txd_ff    <= tx_sh_ff[0];
               end
            end
            S_DATA: begin
               if (tx_cnt_ff == 6'd15) begin
                  tx_cnt_ff <= 6'h0;
                  if (tx_bit_ff == len_m1) begin
                     // parity over the sent bits only
                     if (par_en) begin
                        tx_st_ff <= S_PAR;
                        txd_ff   <= ^(tx_sh_ff & (8'hff >> (3'd7 - len_m1))) ^ ~par_ev;
                     end else begin
                        tx_st_ff <= S_STOP;
                        txd_ff   <= 1'b1;
                     end
                  end else begin
                     tx_bit_ff <= tx_bit_ff + 3'd1;
                     txd_ff    <= tx_sh_ff[tx_bit_ff + 3'd1];
                  end
               end
            end
            S_PAR: begin
               if (tx_cnt_ff == 6'd15) begin
                  tx_cnt_ff <= 6'h0;
                  tx_st_ff  <= S_STOP;
                  txd_ff    <= 1'b1;
               end
            end
            S_STOP: begin
               if (tx_cnt_ff == stop_ticks - 6'd1) begin
                  tx_st_ff <= S_IDLE;
               end
            end
            default: begin
               tx_st_ff <= S_IDLE;
            end
         endcase
         // force break holds the line low whatever is shifting
         if (cmd_ff[`ACS_CMD_BREAK]) begin
            txd_ff <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// [testbench/acs_top_chk.sv]
// checker for the serial block, sees only the top module ports
`timescale 1ns/10ps
`default_nettype none
module acs_top_chk (
   input wire logic       mclk,
   input wire logic       rst_n,
   input wire logic       io_cs,
   input wire logic [1:0] io_addr,
   input wire logic       io_rd,
   input wire logic       io_wr,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata_ff,
   input wire logic       rxd,
   input wire logic       txd_ff,
   input wire logic       rx_int_pend_ff,
   input wire logic       tx_int_pend_ff
);
   wire       st_rd = io_cs && io_rd && (io_addr == 2'h1);   // status read
   wire       md_rd = io_cs && io_rd && (io_addr == 2'h2);   // mode read
   wire       md_wr = io_cs && io_wr && (io_addr == 2'h2);   // mode write
   wire       cm_rd = io_cs && io_rd && (io_addr == 2'h3);   // command read
   wire       cm_wr = io_cs && io_wr && (io_addr == 2'h3);   // command write
   logic       ptr_ff;                                        // shadow of the shared mode pointer
   logic [7:0] m1_ff;                                         // shadow of mode one
   logic [3:0] m2_ff;                                         // shadow of the rate code
   // shadow the mode registers so read-back can be judged
   always @(posedge mclk) begin
      if (!rst_n) begin
         ptr_ff <= 1'b0;
         m1_ff  <= 8'h00;
         m2_ff  <= 4'h0;
      end else if (md_rd || md_wr) begin
         ptr_ff <= ~ptr_ff;
         if (md_wr && !ptr_ff)
            m1_ff <= io_wdata;
         if (md_wr && ptr_ff)
            m2_ff <= io_wdata[3:0];
      end
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   a_status_fixed: assert property (st_rd |=> (io_rdata_ff[7:6] == 2'b11) && !io_rdata_ff[2])
      else $error("status fixed bits wrong");
   a_status_rx_match: assert property (st_rd |=> io_rdata_ff[1] == rx_int_pend_ff)
      else $error("receive ready and receive pending disagree");
   a_status_tx_match: assert property (st_rd |=> io_rdata_ff[0] == tx_int_pend_ff)
      else $error("transmit ready and transmit pending disagree");
   a_tx_off_pend: assert property ((cm_wr && !io_wdata[0]) |-> ##2 !tx_int_pend_ff)
      else $error("transmit pending stays after transmitter off");
   a_rx_off_pend: assert property ((cm_wr && !io_wdata[2]) |-> ##2 !rx_int_pend_ff)
      else $error("receive pending stays after receiver off");
   a_mode_one_echo: assert property ((md_rd && !ptr_ff) |=> io_rdata_ff == m1_ff)
      else $error("mode one read-back wrong");
   a_mode_two_fixed: assert property ((md_rd && ptr_ff) |=> io_rdata_ff == {4'h7, m2_ff})
      else $error("mode two read-back wrong");
   a_cmd_err_zero: assert property (cm_rd |=> !io_rdata_ff[4])
      else $error("reset-error bit reads one");
   a_overrun_sticky: assert property (st_rd ##1 (io_rdata_ff[4] && !cm_wr) ##1 st_rd |=> io_rdata_ff[4])
      else $error("overrun cleared by status read");
   a_frame_read_clr: assert property (st_rd ##2 st_rd |=> !io_rdata_ff[5])
      else $error("framing flag survives status read");
endmodule
`default_nettype wire

// [testbench/acs_line_dev.sv]
// serial line partner: sends frames on rxd and captures frames from txd
`timescale 1ns/10ps
`default_nettype none
module acs_line_dev #(
   parameter int BIT_CYC = 320
) (
   input  wire logic mclk,
   input  wire logic txd,
   output var logic  rxd
);
   // line rests at mark level between frames
   initial begin
      rxd = 1'b1;
   end
   // hold one level for a whole bit time, changed just after the edge like all stimulus
   task automatic put_bit(input logic b);
      #1;
      rxd = b;
      repeat (BIT_CYC) @(posedge mclk);
   endtask
   // start, eight data bits lsb first, optional odd parity, stop, idle bit
   task automatic send(input logic [7:0] dv, input logic par_en, input logic bad_par, input logic bad_stop);
      @(posedge mclk);
      put_bit(1'b0);
      for (int i = 0; i < 8; i++)
         put_bit(dv[i]);
      if (par_en)
         put_bit(~^dv ^ bad_par);
      put_bit(~bad_stop);
      put_bit(1'b1);
   endtask
   // wait for a start bit, sample eight data bits mid-bit, skip parity and stop
   task automatic recv(output logic [7:0] dv);
      int n;
      n = 0;
      while (txd !== 1'b0 && n < 20000) begin
         @(posedge mclk);
         n++;
      end
      repeat (BIT_CYC / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(posedge mclk);
         dv[i] = txd;
      end
      repeat (2 * BIT_CYC) @(posedge mclk);
   endtask
endmodule
`default_nettype wire

// [testbench/acs_top_tb.sv]
// testbench for the serial status, mode and command block
`timescale 1ns/10ps
`default_nettype none
`include "acs_defs.vh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module acs_top_tb;
   localparam int CLK_HZ = 1536000;   // rate code c gives 20 cycles per tick
   localparam int BIT_CYC = 320;      // 16 ticks per bit
   logic       mclk;
   logic       rst_n;
   logic       io_cs;
   logic [1:0] io_addr;
   logic       io_rd;
   logic       io_wr;
   logic [7:0] io_wdata;
   wire logic [7:0] io_rdata_ff;
   wire logic       rxd;
   wire logic       txd_ff;
   wire logic       rx_int_pend_ff;
   wire logic       tx_int_pend_ff;
   int         n_errors = 0;
   int         checks_done = 0;
   logic [7:0] d;                     // last read data
   logic [7:0] b1;                    // first captured character
   logic [7:0] b2;                    // second captured character
   acs_top #(.CLK_HZ(CLK_HZ)) i_acs_top (
      .mclk(mclk), .rst_n(rst_n), .io_cs(io_cs), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
      .io_wdata(io_wdata), .io_rdata_ff(io_rdata_ff), .rxd(rxd), .txd_ff(txd_ff),
      .rx_int_pend_ff(rx_int_pend_ff), .tx_int_pend_ff(tx_int_pend_ff));
   acs_line_dev #(.BIT_CYC(BIT_CYC)) i_acs_line_dev (.mclk(mclk), .txd(txd_ff), .rxd(rxd));
   // free-running clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // one access: strobe held for one edge, read data taken after it
   task automatic bus(input logic rd, input logic [1:0] a, input logic [7:0] wd);
      @(posedge mclk);
      #1;
      io_cs = 1'b1;
      io_rd = rd;
      io_wr = ~rd;
      io_addr = a;
      io_wdata = wd;
      @(posedge mclk);
      #1;
      io_cs = 1'b0;
      io_rd = 1'b0;
      io_wr = 1'b0;
      d = io_rdata_ff;
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      bus(1'b0, a, v);
   endtask
   task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
      bus(1'b1, a, 8'h00);
      `CHK(d, exp)
   endtask
   task automatic send(input logic [7:0] v, input logic pe, input logic bp, input logic bs);
      i_acs_line_dev.send(v, pe, bp, bs);
   endtask
   // counts, verdict and end of run
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // cut a hang short: the tests need about 50000 cycles
   initial begin
      repeat (80000) @(posedge mclk);
      n_errors++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      rst_n = 1'b0;
      io_cs = 1'b0;
      io_rd = 1'b0;
      io_wr = 1'b0;
      io_addr = 2'h0;
      io_wdata = 8'h00;
      repeat (8) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      `CHK(txd_ff, 1'b1)
      rd_chk(`ACS_OFS_STATUS, 8'hc0);
      rd_chk(`ACS_OFS_MODE, 8'h00);
      rd_chk(`ACS_OFS_MODE, 8'h70);
      wr(`ACS_OFS_MODE, 8'h5e);
      wr(`ACS_OFS_MODE, 8'h3c);
      rd_chk(`ACS_OFS_MODE, 8'h5e);
      rd_chk(`ACS_OFS_MODE, 8'h7c);
      wr(`ACS_OFS_CMD, 8'h05);
      rd_chk(`ACS_OFS_STATUS, 8'hc1);
      // second write lands while the first character is still shifting
      fork
         begin
            i_acs_line_dev.recv(b1);
            i_acs_line_dev.recv(b2);
         end
         begin
            wr(`ACS_OFS_DATA, 8'ha5);
            repeat (40) @(posedge mclk);
            wr(`ACS_OFS_DATA, 8'h5a);
            rd_chk(`ACS_OFS_STATUS, 8'hc0);
         end
      join
      `CHK(b1, 8'ha5)
      `CHK(b2, 8'h5a)
      `CHK(tx_int_pend_ff, 1'b1)
      send(8'h3c, 1'b1, 1'b0, 1'b0);
      rd_chk(`ACS_OFS_STATUS, 8'hc3);
      `CHK(rx_int_pend_ff, 1'b1)
      rd_chk(`ACS_OFS_DATA, 8'h3c);
      rd_chk(`ACS_OFS_STATUS, 8'hc1);
      // bad parity, then a clean character replaces the flag
      send(8'h55, 1'b1, 1'b1, 1'b0);
      rd_chk(`ACS_OFS_STATUS, 8'hcb);
      rd_chk(`ACS_OFS_DATA, 8'h55);
      send(8'h0f, 1'b1, 1'b0, 1'b0);
      rd_chk(`ACS_OFS_STATUS, 8'hc3);
      rd_chk(`ACS_OFS_DATA, 8'h0f);
      // broken stop bit, flag gone after one status read
      send(8'h66, 1'b1, 1'b0, 1'b1);
      bus(1'b1, `ACS_OFS_STATUS, 8'h00);
      `CHK(d[5], 1'b1)
      bus(1'b1, `ACS_OFS_STATUS, 8'h00);
      `CHK(d[5], 1'b0)
      wr(`ACS_OFS_CMD, 8'h01);
      rd_chk(`ACS_OFS_STATUS, 8'hc1);
      `CHK(rx_int_pend_ff, 1'b0)
      wr(`ACS_OFS_CMD, 8'h05);
      // five characters into a four-deep buffer
      for (int i = 0; i < 5; i++)
         send(8'(8'h10 + i), 1'b1, 1'b0, 1'b0);
      rd_chk(`ACS_OFS_STATUS, 8'hd3);
      rd_chk(`ACS_OFS_STATUS, 8'hd3);
      for (int i = 0; i < 4; i++)
         rd_chk(`ACS_OFS_DATA, 8'(8'h10 + i));
      wr(`ACS_OFS_CMD, 8'h15);
      rd_chk(`ACS_OFS_STATUS, 8'hc1);
      rd_chk(`ACS_OFS_CMD, 8'h05);
      // parity checking off: the stop bit must not be judged as parity
      wr(`ACS_OFS_MODE, 8'h4e);
      wr(`ACS_OFS_MODE, 8'h7c);
      send(8'h01, 1'b0, 1'b0, 1'b0);
      rd_chk(`ACS_OFS_STATUS, 8'hc3);
      rd_chk(`ACS_OFS_DATA, 8'h01);
      rd_chk(`ACS_OFS_DATA, 8'h00);
      // even parity, seven data bits, 1x sample point: partner bit 7 is the parity bit
      wr(`ACS_OFS_MODE, 8'h79);
      wr(`ACS_OFS_MODE, 8'h7c);
      send(8'hc3, 1'b0, 1'b0, 1'b0);
      rd_chk(`ACS_OFS_STATUS, 8'hc3);
      rd_chk(`ACS_OFS_DATA, 8'h43);
      wr(`ACS_OFS_CMD, 8'h04);
      rd_chk(`ACS_OFS_STATUS, 8'hc0);
      `CHK(tx_int_pend_ff, 1'b0)
      tally_and_finish();
   end
endmodule
bind acs_top acs_top_chk i_acs_top_chk (
   .mclk(mclk), .rst_n(rst_n), .io_cs(io_cs), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
   .io_wdata(io_wdata), .io_rdata_ff(io_rdata_ff), .rxd(rxd), .txd_ff(txd_ff),
   .rx_int_pend_ff(rx_int_pend_ff), .tx_int_pend_ff(tx_int_pend_ff));
`default_nettype wire
